// ### rtl/fecc_top.sv
// Flash erase command checker: launch checks, erase, verify and status flags
`timescale 1ns/1ns
`include "fecc_map.svh"

module fecc_top
    import fecc_pkg::*;
#(
    parameter int CW = `FECC_PFL_WORDS_LOG
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic launch_clear,
    input wire logic [15:0] cmd_param_word0,
    input wire logic [15:0] cmd_param_word1,
    input wire logic [2:0] param_index_field,
    input wire logic cmd_allowed_in_mode,
    input wire logic [7:0] prot_sector_mask,
    input wire logic block_protected_any,
    input wire logic rd_err,
    input wire logic rd_err_uncorr,
    input wire logic status_clear,
    output logic cmd_complete_flag,
    output logic access_error_flag,
    output logic protection_violation_flag,
    output logic verify_error_flag,
    output logic verify_uncorrectable_flag,
    output logic erase_we,
    output logic verify_re,
    output logic [23:0] mem_addr
);
    import fecc_pkg::*;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    fecc_state_e state_r;
    fecc_state_e state_nxt;
    fecc_addr_t gaddr_r;
    fecc_addr_t base_r;
    logic is_sec_r;
    logic cmd_blk_r;
    logic cmd_complete_flag_r;
    logic acc_r;
    logic fpv_r;
    logic mg1_r;
    logic mg0_r;
    logic we_r;
    logic re_r;
    logic [23:0] addr_r;
    logic walk_start;
    logic walk_busy;
    logic [CW-1:0] walk_off;

    // Address range helpers, used by several checks
    function automatic logic in_pflash(input fecc_addr_t a);
        return (a >= `FECC_PFL_BASE) && (a <= `FECC_PFL_LAST);
    endfunction
    function automatic logic in_eeprom(input fecc_addr_t a);
        return (a >= `FECC_EE_BASE) && (a <= `FECC_EE_LAST);
    endfunction

    wire fecc_addr_t addr_in = {cmd_param_word0[7:0], cmd_param_word1};
    wire [7:0] cmd_code = cmd_param_word0[15:8];
    wire cmd_sec = (cmd_code == `FECC_CMD_ERS_SEC);
    wire cmd_blk = (cmd_code == `FECC_CMD_ERS_BLK);
    wire launch = cmd_complete_flag_r && launch_clear;

    // Launch checks on the captured parameters
    // index check
    wire err_idx = (param_index_field != `FECC_IDX_LAUNCH);
    wire err_mode = !cmd_allowed_in_mode || !(is_sec_r || cmd_blk_r);
    wire addr_pfl = in_pflash(gaddr_r);
    wire addr_ee = in_eeprom(gaddr_r);
    wire err_addr = is_sec_r ? !addr_pfl : !(addr_pfl || addr_ee);
    wire err_align = (addr_pfl && (gaddr_r[2:0] != `FECC_PHRASE_ZERO))
                   || (addr_ee && !is_sec_r && gaddr_r[0]);
    wire [2:0] sec_grp = gaddr_r[CW+2:CW];
    wire err_prot = is_sec_r ? prot_sector_mask[sec_grp] : block_protected_any;
    logic idx_bad_r;
    wire any_acc = idx_bad_r || err_mode || err_addr || err_align;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            FECC_IDLE: if (launch) state_nxt = FECC_CHECK;
            FECC_CHECK: state_nxt = (any_acc || err_prot) ? FECC_DONE : FECC_ERASE;
            FECC_ERASE: if (!walk_busy) state_nxt = FECC_VERIFY; // Busy from its first cycle
            FECC_VERIFY: if (!walk_busy) state_nxt = FECC_DONE;
            FECC_DONE: state_nxt = FECC_IDLE;
        endcase
    end

    // Walker starts on entry to erase and verify
    assign walk_start = (state_r == FECC_CHECK && state_nxt == FECC_ERASE)
                      || (state_r == FECC_ERASE && state_nxt == FECC_VERIFY);
    wire erase_done_now = (state_r == FECC_ERASE) && !walk_busy;
    // Walk length from captured command; zero wraps to all 2^CW program flash words
    wire [CW-1:0] span_sel = is_sec_r ? CW'(`FECC_SEC_WORDS)
                           : (addr_ee ? CW'(`FECC_EE_WORDS) : {CW{1'b0}});

    fecc_walker #(.CW(CW)) u_walk (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .start(walk_start),
        .count(span_sel),
        .busy(walk_busy),
        .offset(walk_off)
    );

    // State and capture
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_r <= FECC_IDLE;
            gaddr_r <= '0;
            is_sec_r <= 1'b0;
            cmd_blk_r <= 1'b0;
            idx_bad_r <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            if (launch)
            begin
                gaddr_r <= addr_in;
                is_sec_r <= cmd_sec;
                cmd_blk_r <= cmd_blk;
                idx_bad_r <= err_idx;
            end
        end
    end

    // Erase range: sector for sector erase, whole block otherwise
    // target range
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            base_r <= '0;
        end
        else if (ce && state_r == FECC_CHECK)
        begin
            if (is_sec_r)
            begin
                base_r <= {gaddr_r[23:`FECC_SEC_BITS], {`FECC_SEC_BITS{1'b0}}};
            end
            else if (addr_ee)
            begin
                base_r <= `FECC_EE_BASE;
            end
            else
            begin
                base_r <= `FECC_PFL_BASE;
            end
        end
    end

    // Memory strobes, registered
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            we_r <= 1'b0;
            re_r <= 1'b0;
            addr_r <= '0;
        end
        else if (ce)
        begin
            we_r <= (state_r == FECC_ERASE) && walk_busy;
            re_r <= (state_r == FECC_VERIFY) && walk_busy;
            addr_r <= base_r + 24'(walk_off);
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // complete flag; set wins over a new launch
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cmd_complete_flag_r <= 1'b1;
            acc_r <= 1'b0;
            fpv_r <= 1'b0;
            mg1_r <= 1'b0;
            mg0_r <= 1'b0;
        end
        else if (ce)
        begin
            if (state_r == FECC_DONE)
                cmd_complete_flag_r <= 1'b1;
            else if (launch)
                cmd_complete_flag_r <= 1'b0;
            // Access and protection flags are sticky; a set beats a clear
            acc_r <= (state_r == FECC_CHECK && any_acc) || (acc_r && !status_clear);
            fpv_r <= (state_r == FECC_CHECK && !any_acc && err_prot)
                   || (fpv_r && !status_clear);
            if (launch)
            begin
                mg1_r <= 1'b0;
                mg0_r <= 1'b0;
            end
            else if (re_r)
            begin
                mg1_r <= mg1_r || rd_err || rd_err_uncorr;
                mg0_r <= mg0_r || rd_err_uncorr;
            end
        end
    end

    assign cmd_complete_flag = cmd_complete_flag_r;
    assign access_error_flag = acc_r;
    assign protection_violation_flag = fpv_r;
    assign verify_error_flag = mg1_r;
    assign verify_uncorrectable_flag = mg0_r;
    assign erase_we = we_r;
    assign verify_re = re_r;
    assign mem_addr = addr_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_launch_clears;
        @(posedge clock) disable iff (!rst_n)
        (ce && launch && state_r == FECC_IDLE) |=> !cmd_complete_flag_r;
    endproperty
    a_launch_clears: assert property (p_launch_clears)
        else $error("launch did not clear complete flag");

    property p_done_sets;
        @(posedge clock) disable iff (!rst_n)
        (ce && state_r == FECC_DONE) |=> cmd_complete_flag_r;
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("complete flag not set at done");

    property p_idx_err;
        @(posedge clock) disable iff (!rst_n)
        (ce && state_r == FECC_CHECK && idx_bad_r) |=> acc_r;
    endproperty
    a_idx_err: assert property (p_idx_err)
        else $error("bad index not flagged");

    property p_mode_err;
        @(posedge clock) disable iff (!rst_n)
        (ce && state_r == FECC_CHECK && err_mode) |=> acc_r;
    endproperty
    a_mode_err: assert property (p_mode_err)
        else $error("mode error not flagged");

    property p_addr_err;
        @(posedge clock) disable iff (!rst_n)
        (ce && state_r == FECC_CHECK && err_addr) |=> acc_r;
    endproperty
    a_addr_err: assert property (p_addr_err)
        else $error("address error not flagged");

    property p_align_err;
        @(posedge clock) disable iff (!rst_n)
        (ce && state_r == FECC_CHECK && is_sec_r && gaddr_r[2:0] != `FECC_PHRASE_ZERO)
            |=> acc_r;
    endproperty
    a_align_err: assert property (p_align_err)
        else $error("misaligned sector address not flagged");

    property p_prot_err;
        @(posedge clock) disable iff (!rst_n)
        (ce && state_r == FECC_CHECK && !any_acc && err_prot) |=> fpv_r && cmd_complete_flag_r == 1'b0
            ##0 (state_r == FECC_DONE);
    endproperty
    a_prot_err: assert property (p_prot_err)
        else $error("protection violation not flagged");

    property p_no_erase_on_err;
        @(posedge clock) disable iff (!rst_n)
        (ce && state_r == FECC_CHECK && (any_acc || err_prot)) |=> !we_r [*2];
    endproperty
    a_no_erase_on_err: assert property (p_no_erase_on_err)
        else $error("erase ran after launch error");

    property p_uncorr_implies;
        @(posedge clock) disable iff (!rst_n)
        mg0_r |-> mg1_r;
    endproperty
    a_uncorr_implies: assert property (p_uncorr_implies)
        else $error("uncorrectable set without verify error");

    property p_verify_err;
        @(posedge clock) disable iff (!rst_n)
        (ce && re_r && rd_err && !launch) |=> mg1_r;
    endproperty
    a_verify_err: assert property (p_verify_err)
        else $error("verify error not flagged");

    property p_erase_before_done;
        @(posedge clock) disable iff (!rst_n)
        erase_done_now && ce |=> state_r == FECC_VERIFY;
    endproperty
    a_erase_before_done: assert property (p_erase_before_done)
        else $error("verify did not follow erase");

    c_sector: cover property (@(posedge clock) disable iff (!rst_n)
        state_r == FECC_VERIFY && is_sec_r ##1 state_r == FECC_DONE);
    c_block: cover property (@(posedge clock) disable iff (!rst_n)
        state_r == FECC_ERASE && cmd_blk_r);
    c_acc: cover property (@(posedge clock) disable iff (!rst_n) $rose(acc_r));
    c_mg0: cover property (@(posedge clock) disable iff (!rst_n) $rose(mg0_r));
endmodule

// ### rtl/fecc_map.svh
// Constants for the flash erase command checker
`ifndef FECC_MAP_SVH
`define FECC_MAP_SVH
`define FECC_CMD_ERS_BLK 8'h09
`define FECC_CMD_ERS_SEC 8'h0A
`define FECC_IDX_LAUNCH 3'h1
`define FECC_PHRASE_ZERO 3'h0
`define FECC_PFL_BASE 24'hFF0000
`define FECC_PFL_LAST 24'hFFFFFF
`define FECC_EE_BASE 24'h100000
`define FECC_EE_LAST 24'h100FFF
`define FECC_SEC_BITS 9
`define FECC_SEC_WORDS 9'h100
`define FECC_EE_WORDS 9'h100
`define FECC_PFL_WORDS_LOG 13
`define FECC_CNT_ZERO 13'h0000
`endif

// ### rtl/fecc_pkg.sv
// Types shared by the flash erase command checker
package fecc_pkg;
    typedef enum logic [2:0] {
        FECC_IDLE,
        FECC_CHECK,
        FECC_ERASE,
        FECC_VERIFY,
        FECC_DONE
    } fecc_state_e;
    typedef logic [23:0] fecc_addr_t;
endpackage

// ### rtl/fecc_walker.sv
// Address walker that steps erase and verify over a range of flash words
`timescale 1ns/1ns
`include "fecc_map.svh"
module fecc_walker #(
    parameter int CW = 13
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire logic [CW-1:0] count,
    output logic busy,
    output logic [CW-1:0] offset
);
    logic [CW-1:0] left_r;
    logic [CW-1:0] offset_r;
    logic busy_r;

    assign busy = busy_r;
    assign offset = offset_r;

    // One word per cycle until the range is used up
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            left_r <= '0;
            offset_r <= '0;
        end
        else if (ce)
        begin
            if (start)
            begin
                busy_r <= 1'b1;
                left_r <= count - 1'b1; // Zero wraps to a full 2^CW walk
                offset_r <= '0;
            end
            else if (busy_r)
            begin
                busy_r <= (left_r != '0);
                left_r <= left_r - 1'b1;
                offset_r <= offset_r + 1'b1;
            end
        end
    end
endmodule

// ### verif/fecc_top_tb.sv
// Self-checking testbench for the flash erase command checker
`timescale 1ns/1ns
module fecc_top_tb;
    logic clock, rst_n, ce, launch_clear, cmd_allowed_in_mode, block_protected_any;
    logic rd_err, rd_err_uncorr, status_clear;
    logic [15:0] cmd_param_word0, cmd_param_word1;
    logic [2:0] param_index_field;
    logic [7:0] prot_sector_mask;
    logic cmd_complete_flag, access_error_flag, protection_violation_flag;
    logic verify_error_flag, verify_uncorrectable_flag, erase_we, verify_re;
    logic [23:0] mem_addr;
    int fails = 0;
    int check_count = 0;

    fecc_top fecc_top_inst (
        .clock(clock), .rst_n(rst_n), .ce(ce), .launch_clear(launch_clear),
        .cmd_param_word0(cmd_param_word0), .cmd_param_word1(cmd_param_word1),
        .param_index_field(param_index_field), .cmd_allowed_in_mode(cmd_allowed_in_mode),
        .prot_sector_mask(prot_sector_mask), .block_protected_any(block_protected_any),
        .rd_err(rd_err), .rd_err_uncorr(rd_err_uncorr), .status_clear(status_clear),
        .cmd_complete_flag(cmd_complete_flag), .access_error_flag(access_error_flag),
        .protection_violation_flag(protection_violation_flag),
        .verify_error_flag(verify_error_flag),
        .verify_uncorrectable_flag(verify_uncorrectable_flag),
        .erase_we(erase_we), .verify_re(verify_re), .mem_addr(mem_addr)
    );

    // ----------------------------------------
    // Clock and helpers
    // ----------------------------------------
    // Free-running 50 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Compare one value, four-state exact
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Single place where the run ends
    task stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Launch one command, count strobes, judge flags; a busy relaunch is tried mid-run when strobes are expected
    task run_cmd(input logic [7:0] code, input logic [23:0] addr, input logic [2:0] ix,
                 input logic [15:0] n_exp, input logic [23:0] base, input logic [23:0] span,
                 input logic acc_e, input logic prot_e, input logic ve_e, input logic vu_e);
        int n;
        int ne;
        int nv;
        logic [23:0] lo;
        logic [23:0] hi;
        ne = 0;
        nv = 0;
        lo = 24'hFFFFFF;
        hi = 24'h000000;
        @(posedge clock);
        cmd_param_word0 <= {code, addr[23:16]};
        cmd_param_word1 <= addr[15:0];
        param_index_field <= ix;
        launch_clear <= 1'b1;
        @(posedge clock);
        launch_clear <= 1'b0;
        @(negedge clock);
        chk("complete low after launch", 32'h0, cmd_complete_flag);
        for (n = 0; n < 20000 && cmd_complete_flag !== 1'b1; n++)
        begin
            @(posedge clock);
            // Relaunch while busy must be ignored
            launch_clear <= (n == 4 && n_exp != 16'h0000);
            @(negedge clock);
            if (erase_we === 1'b1)
            begin
                ne++;
                if (mem_addr < lo) lo = mem_addr;
                if (mem_addr > hi) hi = mem_addr;
            end
            if (verify_re === 1'b1) nv++;
        end
        if (n >= 20000)
        begin
            fails++;
            $display("FAIL completion wait expected done seen timeout");
            stop_test();
        end
        chk("erase strobes", {16'h0000, n_exp}, ne);
        chk("verify strobes", {16'h0000, n_exp}, nv);
        if (n_exp != 16'h0000)
        begin
            chk("lowest erase address", {8'h00, base}, {8'h00, lo});
            chk("highest erase in range", 32'h1,
                {31'h0, ({8'h00, hi} < {8'h00, base} + span)});
        end
        else
            chk("early completion", 32'h1, {31'h0, (n <= 4)});
        chk("access error", {31'h0, acc_e}, access_error_flag);
        chk("protection", {31'h0, prot_e}, protection_violation_flag);
        chk("verify error", {31'h0, ve_e}, verify_error_flag);
        chk("uncorrectable", {31'h0, vu_e}, verify_uncorrectable_flag);
    endtask

    // Clear sticky launch error flags and confirm
    task clr();
        @(posedge clock);
        status_clear <= 1'b1;
        @(posedge clock);
        status_clear <= 1'b0;
        @(negedge clock);
        chk("access cleared", 32'h0, access_error_flag);
        chk("protection cleared", 32'h0, protection_violation_flag);
    endtask

    // Clock enable low freezes the block, so a launch pulse is not taken
    task ce_hold();
        @(posedge clock);
        ce <= 1'b0;
        launch_clear <= 1'b1;
        @(posedge clock);
        launch_clear <= 1'b0;
        @(posedge clock);
        ce <= 1'b1;
        @(negedge clock);
        chk("frozen complete", 32'h1, cmd_complete_flag);
        chk("frozen erase strobe", 32'h0, erase_we);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        launch_clear = 1'b0;
        cmd_param_word0 = 16'h0000;
        cmd_param_word1 = 16'h0000;
        param_index_field = 3'h1;
        cmd_allowed_in_mode = 1'b1;
        prot_sector_mask = 8'h00;
        block_protected_any = 1'b0;
        rd_err = 1'b0;
        rd_err_uncorr = 1'b0;
        status_clear = 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk("reset complete", 32'h1, cmd_complete_flag);
        chk("reset access", 32'h0, access_error_flag);
        ce_hold();
        // Good sector erase, address inside sector
        run_cmd(8'h0A, 24'hFF2340, 3'h1, 16'h0100, 24'hFF2200, 24'h200, 0, 0, 0, 0);
        rd_err <= 1'b1;
        run_cmd(8'h0A, 24'hFFFFF8, 3'h1, 16'h0100, 24'hFFFE00, 24'h200, 0, 0, 1, 0);
        rd_err <= 1'b0;
        rd_err_uncorr <= 1'b1;
        run_cmd(8'h0A, 24'hFF0000, 3'h1, 16'h0100, 24'hFF0000, 24'h200, 0, 0, 1, 1);
        rd_err_uncorr <= 1'b0;
        // Block erases; verify flags must be cleared by the launch
        run_cmd(8'h09, 24'h100000, 3'h1, 16'h0100, 24'h100000, 24'h1000, 0, 0, 0, 0);
        run_cmd(8'h09, 24'hFF0000, 3'h1, 16'h2000, 24'hFF0000, 24'h10000, 0, 0, 0, 0);
        // Launch errors skip the erase
        run_cmd(8'h0A, 24'hFF2340, 3'h2, 16'h0000, 24'h0, 24'h0, 1, 0, 0, 0);
        clr();
        run_cmd(8'h09, 24'h100000, 3'h0, 16'h0000, 24'h0, 24'h0, 1, 0, 0, 0);
        clr();
        cmd_allowed_in_mode <= 1'b0;
        run_cmd(8'h0A, 24'hFF2340, 3'h1, 16'h0000, 24'h0, 24'h0, 1, 0, 0, 0);
        cmd_allowed_in_mode <= 1'b1;
        clr();
        // Unknown command code counts as not allowed
        run_cmd(8'h0B, 24'hFF2340, 3'h1, 16'h0000, 24'h0, 24'h0, 1, 0, 0, 0);
        clr();
        run_cmd(8'h0A, 24'h500000, 3'h1, 16'h0000, 24'h0, 24'h0, 1, 0, 0, 0);
        clr();
        run_cmd(8'h0A, 24'hFF2344, 3'h1, 16'h0000, 24'h0, 24'h0, 1, 0, 0, 0);
        clr();
        run_cmd(8'h09, 24'h100001, 3'h1, 16'h0000, 24'h0, 24'h0, 1, 0, 0, 0);
        clr();
        run_cmd(8'h09, 24'hFF0002, 3'h1, 16'h0000, 24'h0, 24'h0, 1, 0, 0, 0);
        clr();
        // Sector 0xFF2340 sits in the second eighth of program flash
        prot_sector_mask <= 8'h02;
        run_cmd(8'h0A, 24'hFF2340, 3'h1, 16'h0000, 24'h0, 24'h0, 0, 1, 0, 0);
        clr();
        prot_sector_mask <= 8'hFD;
        run_cmd(8'h0A, 24'hFF2340, 3'h1, 16'h0100, 24'hFF2200, 24'h200, 0, 0, 0, 0);
        prot_sector_mask <= 8'h00;
        block_protected_any <= 1'b1;
        run_cmd(8'h09, 24'h100000, 3'h1, 16'h0000, 24'h0, 24'h0, 0, 1, 0, 0);
        block_protected_any <= 1'b0;
        clr();
        stop_test();
    end
endmodule
